// ---- srb_fifo.sv ----
// srb_fifo: small entry buffer for received characters, oldest first.
// assumes the writer pushes into a full buffer only together with a pop, and the reader never pops when empty.
`timescale 1ns/1ps
`default_nettype none
module srb_fifo
  import srb_pkg::*;
#(
  parameter int WIDTH = SRB_ENTRY_W,
  parameter int DEPTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic                  empty_o,
  output logic                  full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    rptr_q;
  logic [AW:0]      cnt_q;
  logic             do_push;
  logic             do_pop;

  // a push into a full buffer is taken when a pop frees the head slot in the same cycle
  assign do_push = push_i && (!full_o || pop_i);
  assign do_pop  = pop_i && !empty_o;
  assign empty_o = (cnt_q == '0);
  assign full_o  = (cnt_q == (AW+1)'(DEPTH));

  // storage; no reset needed since count guards reads
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_q[wptr_q] <= wdata_i;
    end
  end

  // pointers and count; flush empties at once
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else if (flush_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (do_push) begin
        wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
      end
      if (do_pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // registered head entry, zero when empty
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_o;
      if (flush_i) begin
        rdata_o <= '0;
      end else if (do_pop) begin
        if (cnt_q > (AW+1)'(1)) begin
          rdata_o <= mem_q[(rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1];
        end else if (do_push) begin
          rdata_o <= wdata_i;
        end else begin
          rdata_o <= '0;
        end
      end else if (do_push && empty_o) begin
        rdata_o <= wdata_i;
      end
    end
  end
endmodule : srb_fifo
`default_nettype wire

// ---- srb_frame.sv ----
// srb_frame: takes one bit per strobe from the recovered bit stream and assembles a frame.
// assumes bit_valid_i pulses once per recovered bit, start bit first, from the clock/data recovery.
`timescale 1ns/1ps
`default_nettype none
module srb_frame
  import srb_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       enable_i,
  input  wire logic       bit_valid_i,
  input  wire logic       bit_i,
  input  wire logic [3:0] data_bits_i,
  input  wire logic       parity_en_i,
  output logic            start_o,
  output logic            done_o,
  output logic [8:0]      data_o,
  output logic            parity_bit_o,
  output logic            stop_bit_o
);
  srb_rx_state_t state_q;
  logic [3:0]    cnt_q;
  logic [3:0]    need;

  // data bits plus an optional parity bit precede the stop bit
  assign need    = data_bits_i + 4'(parity_en_i);
  assign start_o = enable_i && bit_valid_i && (state_q == SRB_IDLE) && !bit_i;

  // frame sequencer; disabling abandons any frame at once
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q      <= SRB_IDLE;
      cnt_q        <= '0;
      data_o       <= '0;
      parity_bit_o <= 1'b0;
      stop_bit_o   <= 1'b1;
      done_o       <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!enable_i) begin
        state_q <= SRB_IDLE;
      end else if (bit_valid_i) begin
        unique case (state_q)
          SRB_IDLE: begin
            if (!bit_i) begin
              state_q <= SRB_BITS;
              cnt_q   <= '0;
              data_o  <= '0; // unused upper bits stay zero
            end
          end
          SRB_BITS: begin
            if (cnt_q < data_bits_i) begin
              data_o[cnt_q] <= bit_i;
            end else begin
              parity_bit_o <= bit_i;
            end
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q + 4'h1 == need) begin
              state_q <= SRB_STOP;
            end
          end
          SRB_STOP: begin
            // only the first stop bit is looked at
            stop_bit_o <= bit_i;
            done_o     <= 1'b1;
            state_q    <= SRB_IDLE;
          end
          default: state_q <= SRB_IDLE;
        endcase
      end
    end
  end
endmodule : srb_frame
`default_nettype wire

// ---- srb_pkg.sv ----
// srb_pkg: register map, field positions, reset values and state codes for the serial receive buffer block.
// assumes a 32-bit avalon-mm slave with word-aligned registers.
package srb_pkg;
  // register byte offsets
  localparam logic [3:0] SRB_STATUS_OFS = 4'h0; // serial_status_register
  localparam logic [3:0] SRB_CTRLB_OFS  = 4'h4; // serial_control_register_b
  localparam logic [3:0] SRB_CTRLC_OFS  = 4'h8; // serial_control_register_c
  localparam logic [3:0] SRB_DATA_OFS   = 4'hC; // serial_data_location
  // status register fields
  localparam int SRB_ST_PE_BIT  = 2;
  localparam int SRB_ST_DOR_BIT = 3;
  localparam int SRB_ST_FE_BIT  = 4;
  localparam int SRB_ST_RXC_BIT = 7;
  // control b fields
  localparam int SRB_CB_RXB8_BIT  = 1;
  localparam int SRB_CB_SZ2_BIT   = 2;
  localparam int SRB_CB_RXEN_BIT  = 4;
  localparam int SRB_CB_RXCIE_BIT = 7;
  // control c fields
  localparam int SRB_CC_SZ0_BIT  = 1;
  localparam int SRB_CC_SZ1_BIT  = 2;
  localparam int SRB_CC_STOP_BIT = 3;
  localparam int SRB_CC_PODD_BIT = 4;
  localparam int SRB_CC_PEN_BIT  = 5;
  // reset values
  localparam logic [7:0] SRB_CTRLB_RST = 8'h00;
  localparam logic [7:0] SRB_CTRLC_RST = 8'h06; // eight data bits, no parity
  // character size code for nine data bits
  localparam logic [2:0] SRB_SIZE_NINE = 3'h7;
  // buffer entry layout: data[8:0], fe, dor, pe
  localparam int SRB_ENTRY_W = 12;
  localparam int SRB_E_FE    = 9;
  localparam int SRB_E_DOR   = 10;
  localparam int SRB_E_PE    = 11;
  // receiver frame states
  typedef enum logic [1:0] {
    SRB_IDLE = 2'b00,
    SRB_BITS = 2'b01,
    SRB_STOP = 2'b10
  } srb_rx_state_t;
endpackage : srb_pkg

// ---- srb_rx.sv ----
// srb_rx: receive buffer, receive-complete flag, error flags and parity check of a serial port.
// assumes recovered bits arrive as strobes on rx_bit_valid_i; registers over avalon-mm, one word each.
`timescale 1ns/1ps
`default_nettype none
module srb_rx
  import srb_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // recovered bit stream and system
  input  wire logic        rx_bit_valid_i,
  input  wire logic        rx_bit_i,
  input  wire logic        global_irq_enable_i,
  output logic             rx_pin_override_o,
  output logic             rx_complete_irq_o
);
  logic [7:0]             ctrlb_q;
  logic [7:0]             ctrlc_q;
  logic                   ack_q;
  logic                   hold_q;
  logic [8:0]             hold_data_q;
  logic                   hold_fe_q;
  logic                   hold_pe_q;
  logic                   dor_pend_q;
  logic                   rx_en;
  logic [2:0]             size_code;
  logic [3:0]             data_bits;
  logic                   par_en;
  logic                   start;
  logic                   done;
  logic [8:0]             fr_data;
  logic                   fr_par;
  logic                   fr_stop;
  logic                   par_calc;
  logic [SRB_ENTRY_W-1:0] head;
  logic                   fifo_empty;
  logic                   fifo_full;
  logic                   push;
  logic                   pop;
  logic                   req;
  logic [SRB_ENTRY_W-1:0] push_entry;
  logic [7:0]             status_rd;
  logic [7:0]             ctrlb_rd;

  assign rx_en     = ctrlb_q[SRB_CB_RXEN_BIT];
  assign size_code = {ctrlb_q[SRB_CB_SZ2_BIT], ctrlc_q[SRB_CC_SZ1_BIT], ctrlc_q[SRB_CC_SZ0_BIT]};
  assign par_en    = ctrlc_q[SRB_CC_PEN_BIT];
  assign rx_pin_override_o = rx_en; // pin returns to port use when disabled

  // character size: codes 0..3 give 5..8 bits, 7 gives nine
  always_comb begin
    data_bits = 4'h8;
    if (size_code == SRB_SIZE_NINE) begin
      data_bits = 4'h9;
    end else if (!size_code[2]) begin
      data_bits = 4'h5 + {2'b00, size_code[1:0]};
    end
  end

  srb_frame u_frame (
    .clock_i      (clock_i),
    .arst_n_i     (arst_n_i),
    .enable_i     (rx_en),
    .bit_valid_i  (rx_bit_valid_i),
    .bit_i        (rx_bit_i),
    .data_bits_i  (data_bits),
    .parity_en_i  (par_en),
    .start_o      (start),
    .done_o       (done),
    .data_o       (fr_data),
    .parity_bit_o (fr_par),
    .stop_bit_o   (fr_stop)
  );

  // parity over data bits plus parity bit; odd select inverts the expectation
  assign par_calc = ^{fr_data, fr_par} ^ ctrlc_q[SRB_CC_PODD_BIT];

  // bus handshake: one wait cycle, then answer
  assign req               = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_waitrequest_o = req;
  assign pop = ack_q && avs_read_i && (avs_address_i == SRB_DATA_OFS) && !fifo_empty;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // control registers; status register writes change nothing
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrlb_q <= SRB_CTRLB_RST;
      ctrlc_q <= SRB_CTRLC_RST;
    end else if (ack_q && avs_write_i && avs_byteenable_i[0]) begin
      if (avs_address_i == SRB_CTRLB_OFS) begin
        ctrlb_q <= avs_writedata_i[7:0];
      end else if (avs_address_i == SRB_CTRLC_OFS) begin
        ctrlc_q <= avs_writedata_i[7:0];
      end
    end
  end

  // holding stage stands for the shift register: a finished frame waits here while the buffer is full,
  // and a later frame overwrites it, so the overrun mark lands on the frame after the lost one
  assign push_entry = {hold_pe_q, dor_pend_q, hold_fe_q, hold_data_q};
  assign push       = hold_q && (!fifo_full || pop);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_q      <= 1'b0;
      hold_data_q <= '0;
      hold_fe_q   <= 1'b0;
      hold_pe_q   <= 1'b0;
    end else if (!rx_en) begin
      hold_q <= 1'b0;
    end else if (done) begin
      hold_q      <= 1'b1;
      hold_data_q <= fr_data;
      hold_fe_q   <= !fr_stop;
      hold_pe_q   <= par_en && par_calc; // zero when checking off
    end else if (push) begin
      hold_q <= 1'b0;
    end
  end

  // overrun: flagged when a new start comes while a frame waits and the buffer is full; the new frame's end overwrites the waiting one
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dor_pend_q <= 1'b0;
    end else if (!rx_en) begin
      dor_pend_q <= 1'b0;
    end else if (start && hold_q && fifo_full && !pop) begin
      dor_pend_q <= 1'b1;
    end else if (push) begin
      dor_pend_q <= 1'b0; // cleared once a frame moves
    end
  end

  // the flag rides with the frame that follows the lost one

  srb_fifo #(
    .WIDTH (SRB_ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .flush_i  (!rx_en),
    .push_i   (push),
    .wdata_i  (push_entry),
    .pop_i    (pop),
    .rdata_o  (head),
    .empty_o  (fifo_empty),
    .full_o   (fifo_full)
  );

  // status view of the head entry; flags stored per frame
  always_comb begin
    status_rd = 8'h00;
    status_rd[SRB_ST_RXC_BIT] = !fifo_empty;
    status_rd[SRB_ST_FE_BIT]  = head[SRB_E_FE];
    status_rd[SRB_ST_DOR_BIT] = head[SRB_E_DOR];
    status_rd[SRB_ST_PE_BIT]  = head[SRB_E_PE];
    ctrlb_rd = ctrlb_q;
    ctrlb_rd[SRB_CB_RXB8_BIT] = head[8]; // ninth bit of head entry
  end

  // read data registered at the edge that ends the wait cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= '0;
    end else if (req && avs_read_i) begin
      unique case (avs_address_i)
        SRB_STATUS_OFS: avs_readdata_o <= {24'h000000, status_rd};
        SRB_CTRLB_OFS:  avs_readdata_o <= {24'h000000, ctrlb_rd};
        SRB_CTRLC_OFS:  avs_readdata_o <= {24'h000000, ctrlc_q};
        SRB_DATA_OFS:   avs_readdata_o <= {24'h000000, head[7:0]};
        default:        avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // level interrupt, only from receive complete, never from error flags
  assign rx_complete_irq_o = ctrlb_q[SRB_CB_RXCIE_BIT] && !fifo_empty && global_irq_enable_i;
endmodule : srb_rx
`default_nettype wire

// ---- srb_rx_asserts.sv ----
// srb_rx_chk: port-level assertions for the serial receive block.
// assumes it is bound to srb_rx and sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module srb_rx_chk
  import srb_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        rx_bit_valid_i,
  input wire logic        rx_bit_i,
  input wire logic        global_irq_enable_i,
  input wire logic        rx_pin_override_o,
  input wire logic        rx_complete_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // bus steps: one wait cycle, then the completing cycle
  sequence s_ack;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  sequence s_ctrlb_wr;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == SRB_CTRLB_OFS;
  endsequence
  sequence s_stat_rd;
    avs_read_i && !avs_waitrequest_o && avs_address_i == SRB_STATUS_OFS;
  endsequence
  a_wait_first: assert property (($rose(avs_read_i) || $rose(avs_write_i)) |-> s_ack)
    else $error("waitrequest not one cycle");
  a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data above bit 7 set");
  a_rxc_status: assert property (s_stat_rd ##0 $past(rx_complete_irq_o) |-> avs_readdata_o[SRB_ST_RXC_BIT])
    else $error("status empty while irq pending");
  a_override_follow: assert property (s_ctrlb_wr |=> rx_pin_override_o == $past(avs_writedata_i[4]))
    else $error("pin override not following enable");
  a_irq_gated: assert property (rx_complete_irq_o |-> global_irq_enable_i)
    else $error("irq without global enable");
  a_disable_quiet: assert property (!rx_pin_override_o && !$past(rx_pin_override_o) |-> !rx_complete_irq_o)
    else $error("irq while receiver off");
  // the irq only rises after a stop strobe lands, a register write or the global gate opening
  a_irq_rise_cause: assert property ($rose(rx_complete_irq_o) |-> $past(rx_bit_valid_i, 2) ||
    $past(rx_bit_valid_i, 3) || $past(rx_bit_valid_i, 4) || $past(avs_write_i) || $rose(global_irq_enable_i))
    else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(rx_complete_irq_o) |->
    $past(avs_read_i) || $past(avs_write_i) || $past(avs_write_i, 2) || $fell(global_irq_enable_i))
    else $error("irq fell without read");
endmodule : srb_rx_chk
bind srb_rx srb_rx_chk #(.DEPTH(DEPTH)) i_srb_rx_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_bit_valid_i(rx_bit_valid_i),
  .rx_bit_i(rx_bit_i), .global_irq_enable_i(global_irq_enable_i), .rx_pin_override_o(rx_pin_override_o),
  .rx_complete_irq_o(rx_complete_irq_o));
`default_nettype wire

// ---- srb_tx_model.sv ----
// srb_tx_model: remote transmitter as seen after bit recovery, one strobe per bit.
// assumes its tasks are called from a process synchronised to the rising edge.
`timescale 1ns/1ps
`default_nettype none
module srb_tx_model (
  input  wire logic clock_i,
  output logic      bit_valid_o,
  output logic      bit_o
);
  initial begin
    bit_valid_o = 1'b0;
    bit_o = 1'b1;
  end
  // off-strobe the line shows the inverse, so sampling without a strobe reads wrong data
  task automatic put(input logic b);
    @(posedge clock_i);
    bit_valid_o <= 1'b1;
    bit_o <= b;
    @(posedge clock_i);
    bit_valid_o <= 1'b0;
    bit_o <= ~b;
  endtask : put
  // start, data lsb first, parity if enabled (bad flips it), first stop only
  task automatic send(input int nb, input logic [8:0] d, input logic pen, input logic podd,
                      input logic bad, input logic stp);
    logic p;
    p = podd ^ bad;
    put(1'b0);
    for (int i = 0; i < nb; i++) begin
      put(d[i]);
      p = p ^ d[i];
    end
    if (pen) begin
      put(p);
    end
    put(stp);
  endtask : send
endmodule : srb_tx_model
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for srb_rx with a frame table and hand-written cases.
// assumes srb_pkg, srb_rx, srb_tx_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import srb_pkg::*;
;
  // row: size code, {pen, odd, bad parity, two stops, stop}, sent, expected data, {fe, pe}
  typedef struct packed {
    logic [2:0] sz;
    logic [4:0] f;
    logic [8:0] d;
    logic [8:0] ed;
    logic [1:0] e;
  } srb_row_t;
  logic        clock_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, rx_bit_valid_i, rx_bit_i;
  logic        global_irq_enable_i, rx_pin_override_o, rx_complete_irq_o;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  int          num_errors, n_compared;
  srb_row_t    rows [8];

  srb_rx #(.DEPTH(2)) i_srb_rx (.clock_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rx_bit_valid_i, .rx_bit_i,
    .global_irq_enable_i, .rx_pin_override_o, .rx_complete_irq_o);
  srb_tx_model i_srb_tx_model (.clock_i, .bit_valid_o(rx_bit_valid_i), .bit_o(rx_bit_i));

  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one avalon transfer; held until waitrequest is sampled low at a rising edge, data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  // polling is bounded; a miss shows up in the following status compare
  task automatic wait_rxc();
    logic [31:0] s;
    s = 32'h0;
    for (int n = 0; n < 30 && s[SRB_ST_RXC_BIT] !== 1'b1; n++) bus(1'b0, SRB_STATUS_OFS, 32'h0, s);
  endtask : wait_rxc
  task automatic chk_irq(input logic e);
    @(negedge clock_i);
    check(32'(rx_complete_irq_o), 32'(e));
  endtask : chk_irq
  // status first, then ninth bit, then data, as software must
  task automatic rd_frame(input logic [31:0] est, input logic e9, input logic [7:0] ed);
    logic [31:0] v;
    bus(1'b0, SRB_STATUS_OFS, 32'h0, v);
    check(v & 32'h9C, est);
    bus(1'b0, SRB_CTRLB_OFS, 32'h0, v);
    check(32'(v[SRB_CB_RXB8_BIT]), 32'(e9));
    bus(1'b0, SRB_DATA_OFS, 32'h0, v);
    check(v, 32'(ed));
  endtask : rd_frame

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    close_out();
  end
  initial begin
    {arst_n_i, avs_read_i, avs_write_i, global_irq_enable_i} = 4'h0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    num_errors = 0;
    n_compared = 0;
    rows = '{'{3'h3, 5'h01, 9'h0A5, 9'h0A5, 2'h0}, '{3'h0, 5'h03, 9'h1F3, 9'h013, 2'h0},
             '{3'h7, 5'h11, 9'h1C3, 9'h1C3, 2'h0}, '{3'h2, 5'h15, 9'h055, 9'h055, 2'h1},
             '{3'h1, 5'h19, 9'h02A, 9'h02A, 2'h0}, '{3'h3, 5'h02, 9'h03C, 9'h03C, 2'h2},
             '{3'h7, 5'h1C, 9'h0FF, 9'h0FF, 2'h3}, '{3'h3, 5'h05, 9'h081, 9'h081, 2'h0}};
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    bus(1'b0, SRB_CTRLB_OFS, 32'h0, r);
    check(r, 32'(SRB_CTRLB_RST));
    bus(1'b0, SRB_CTRLC_OFS, 32'h0, r);
    check(r, 32'(SRB_CTRLC_RST));
    bus(1'b0, SRB_STATUS_OFS, 32'h0, r);
    check(r, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, SRB_CTRLC_OFS, {26'h0, rows[i].f[4:3], rows[i].f[1], rows[i].sz[1:0], 1'b0}, r);
      bus(1'b1, SRB_CTRLB_OFS, {27'h0, 1'b1, 1'b0, rows[i].sz[2], 2'h0}, r);
      i_srb_tx_model.send(rows[i].sz == 3'h7 ? 9 : 5 + int'(rows[i].sz), rows[i].d, rows[i].f[4],
                          rows[i].f[3], rows[i].f[2], rows[i].f[0]);
      wait_rxc();
      rd_frame({24'h0, 1'b1, 2'h0, rows[i].e[1], 1'b0, rows[i].e[0], 2'h0}, rows[i].ed[8], rows[i].ed[7:0]);
      bus(1'b0, SRB_STATUS_OFS, 32'h0, r);
      check(32'(r[SRB_ST_RXC_BIT]), 32'h0);
    end
    // nobody reads: the fourth start finds buffer and holding stage full
    for (int k = 1; k < 5; k++) begin
      repeat (6) @(posedge clock_i);
      i_srb_tx_model.send(8, 9'(8'h11 * k), 1'b0, 1'b0, 1'b0, 1'b1);
    end
    rd_frame(32'h80, 1'b0, 8'h11);
    rd_frame(32'h80, 1'b0, 8'h22);
    rd_frame(32'h88, 1'b0, 8'h44);
    i_srb_tx_model.send(8, 9'h055, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    rd_frame(32'h80, 1'b0, 8'h55);
    // a framing error never interrupts; the completion interrupt follows its enables
    global_irq_enable_i <= 1'b1;
    i_srb_tx_model.send(8, 9'h0C3, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_rxc();
    chk_irq(1'b0);
    bus(1'b1, SRB_STATUS_OFS, 32'h1C, r);
    bus(1'b1, SRB_STATUS_OFS, 32'h0, r);
    bus(1'b1, SRB_CTRLB_OFS, 32'h90, r);
    chk_irq(1'b1);
    @(posedge clock_i);
    global_irq_enable_i <= 1'b0;
    chk_irq(1'b0);
    @(posedge clock_i);
    global_irq_enable_i <= 1'b1;
    rd_frame(32'h90, 1'b0, 8'hC3);
    chk_irq(1'b0);
    // a write without byte lane 0 and an unmapped write change nothing
    @(posedge clock_i);
    avs_byteenable_i <= 4'hE;
    bus(1'b1, SRB_CTRLC_OFS, 32'h30, r);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, SRB_CTRLC_OFS, 32'h0, r);
    check(r, 32'(SRB_CTRLC_RST));
    bus(1'b1, 4'h2, 32'hFF, r);
    bus(1'b0, 4'h2, 32'h0, r);
    check(r, 32'h0);
    // two frames waiting and a third half received when the receiver is switched off
    bus(1'b1, SRB_CTRLB_OFS, 32'h10, r);
    i_srb_tx_model.send(8, 9'h0A1, 1'b0, 1'b0, 1'b0, 1'b1);
    i_srb_tx_model.send(8, 9'h0A2, 1'b0, 1'b0, 1'b0, 1'b1);
    i_srb_tx_model.put(1'b0);
    i_srb_tx_model.put(1'b1);
    bus(1'b1, SRB_CTRLB_OFS, 32'h0, r);
    bus(1'b0, SRB_STATUS_OFS, 32'h0, r);
    check(r, 32'h0);
    check(32'(rx_pin_override_o), 32'h0);
    bus(1'b1, SRB_CTRLB_OFS, 32'h10, r);
    i_srb_tx_model.send(8, 9'h05A, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    rd_frame(32'h80, 1'b0, 8'h5A);
    // software flush: keep reading data until the complete flag drops
    i_srb_tx_model.send(8, 9'h0B1, 1'b0, 1'b0, 1'b0, 1'b1);
    i_srb_tx_model.send(8, 9'h0B2, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    r = 32'h80;
    for (int k = 0; k < 4 && r[SRB_ST_RXC_BIT] === 1'b1; k++) begin
      bus(1'b0, SRB_DATA_OFS, 32'h0, r);
      bus(1'b0, SRB_STATUS_OFS, 32'h0, r);
    end
    check(r, 32'h0);
    // reset in mid-run with a frame waiting: buffer and controls return to their reset view
    i_srb_tx_model.send(8, 9'h033, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    bus(1'b0, SRB_STATUS_OFS, 32'h0, r);
    check(r, 32'h0);
    bus(1'b0, SRB_CTRLB_OFS, 32'h0, r);
    check(r, 32'(SRB_CTRLB_RST));
    check(32'(rx_pin_override_o), 32'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
